// File: hw/agt_pkg.sv
// What this block does
// - The in-phase gain trim is a 9-bit code in bits 15:7 of its register; the host writes bits 6:0 as ones.
// - The gain code maps linearly and monotonically to full scale: zero 560 mV, midscale 700 mV, all ones 840 mV.
// - After power-on the gain code is midscale, which applies no adjustment.
// - A new gain trim takes effect at once, with no recalibration.
// - The quadrature offset magnitude is bits 15:8, linear and monotonic from zero to about 45 mV.
// - Bit 7 of the offset register picks polarity, zero positive and one negative; bits 6:0 are written as ones.
// - After power-on the offset magnitude and polarity are zero, so there is no offset.
package agt_pkg;
   // ==========================================================
   // Register map (index times four gives the byte address)
   localparam logic [7:0]  AGT_IDX_GAIN    = 8'h03;
   localparam logic [7:0]  AGT_IDX_OFFSET  = 8'h0a;
   localparam logic [7:0]  AGT_IDX_STATUS  = 8'h00;
   localparam int          AGT_ADDR_LSB    = 2;
   localparam int          AGT_ADDR_W      = 8;

   // ==========================================================
   // Field layout
   localparam int          AGT_GAIN_W      = 9;
   localparam int          AGT_GAIN_LSB    = 7;
   localparam int          AGT_OFS_W       = 8;
   localparam int          AGT_OFS_LSB     = 8;
   localparam int          AGT_SIGN_BIT    = 7;
   localparam int          AGT_CNT_W       = 8;

   // ==========================================================
   // Reset values
   localparam logic [15:0] AGT_GAIN_RST    = 16'h807f;
   localparam logic [15:0] AGT_OFFSET_RST  = 16'h007f;

   // ==========================================================
   // Full-scale mapping in millivolts
   localparam int          AGT_FS_W        = 10;
   localparam int          AGT_FS_MIN_MV   = 560;
   localparam int          AGT_FS_SPAN_MV  = 280;
   localparam int          AGT_GAIN_MAX    = 511;

   // ==========================================================
   // AHB-Lite encodings
   localparam logic [1:0]  AGT_HTRANS_NSEQ = 2'h2;
   localparam logic [2:0]  AGT_HSIZE_WORD  = 3'h2;
   localparam logic        AGT_HRESP_OKAY  = 1'b0;
endpackage : agt_pkg

// File: hw/agt_trim_if.sv
`timescale 1ns/1ps
// Trim codes travelling from the register bank to the mapper
interface agt_trim_if;
   import agt_pkg::*;
   logic [AGT_GAIN_W-1:0] gain_code;
   logic [AGT_OFS_W-1:0]  ofs_mag;
   logic                  ofs_neg;
   modport bank (output gain_code, output ofs_mag, output ofs_neg);
   modport map  (input gain_code, input ofs_mag, input ofs_neg);
endinterface : agt_trim_if

// File: hw/agt_trim_map.sv
`timescale 1ns/1ps
// Turns trim codes into registered analog control words
module agt_trim_map
   import agt_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   agt_trim_if.map                     trim,
   output      logic [AGT_FS_W-1:0]    fs_mv_reg,
   output      logic [AGT_OFS_W:0]     ofs_steps_reg
);
   logic [AGT_FS_W-1:0] fs_mv_next;
   logic [AGT_OFS_W:0]  ofs_steps_next;
   logic [31:0]         prod;

   // ==========================================================
   // Linear rounded map, endpoints exact
   always_comb begin
      prod       = 32'(trim.gain_code) * 32'(AGT_FS_SPAN_MV) + 32'(AGT_GAIN_MAX / 2);
      fs_mv_next = AGT_FS_W'(AGT_FS_MIN_MV) + AGT_FS_W'(prod / 32'(AGT_GAIN_MAX));
   end

   // Signed offset in code steps
   always_comb begin
      ofs_steps_next = trim.ofs_neg ? -{1'b0, trim.ofs_mag}
                                    :  {1'b0, trim.ofs_mag};
   end

   // Applied every cycle, no recalibration step
   always_ff @(posedge clk) begin
      if (rst) begin
         fs_mv_reg     <= AGT_FS_W'(AGT_FS_MIN_MV + AGT_FS_SPAN_MV / 2);
         ofs_steps_reg <= '0;
      end else begin
         fs_mv_reg     <= fs_mv_next;
         ofs_steps_reg <= ofs_steps_next;
      end
   end
endmodule : agt_trim_map

// File: hw/agt_trim_regs.sv
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
// Gain and offset trim register bank on AHB-Lite
module agt_trim_regs
   import agt_pkg::*;
(
   input  wire logic                  SYS_CLK,
   input  wire logic                  SYS_RST,
   input  wire logic                  HSEL,
   input  wire logic [31:0]           HADDR,
   input  wire logic [1:0]            HTRANS,
   input  wire logic                  HWRITE,
   input  wire logic [2:0]            HSIZE,
   input  wire logic [31:0]           HWDATA,
   input  wire logic                  HREADY,
   output      logic [31:0]           HRDATA,
   output      logic                  HREADYOUT,
   output      logic                  HRESP,
   output      logic [AGT_GAIN_W-1:0] GAIN_CODE,
   output      logic [AGT_FS_W-1:0]   GAIN_FS_MV,
   output      logic [AGT_OFS_W-1:0]  OFFSET_MAG,
   output      logic                  OFFSET_NEG,
   output      logic [AGT_OFS_W:0]    OFFSET_STEPS
);
   import agt_pkg::*;

   agt_trim_if trim ();

   logic                  wr_pend_reg;
   logic [AGT_ADDR_W-1:0] wr_idx_reg;
   logic [AGT_GAIN_W-1:0] gain_reg;
   logic [AGT_OFS_W-1:0]  ofs_mag_reg;
   logic                  ofs_neg_reg;
   logic [AGT_CNT_W-1:0]  wr_cnt_reg;
   logic [31:0]           rdata_reg;
   logic [31:0]           rdata_next;
   logic                  addr_ok;
   logic                  wr_take;
   logic                  rd_take;
   logic [AGT_ADDR_W-1:0] a_idx;

   // Word index from a byte address
   function automatic logic [AGT_ADDR_W-1:0] idx_of(input logic [31:0] a);
      idx_of = a[AGT_ADDR_LSB +: AGT_ADDR_W];
   endfunction : idx_of

   // ==========================================================
   // Address phase decode
   always_comb begin
      a_idx   = idx_of(HADDR);
      addr_ok = HSEL && HREADY && (HTRANS == AGT_HTRANS_NSEQ) && (HSIZE == AGT_HSIZE_WORD);
      wr_take = addr_ok && HWRITE;
      rd_take = addr_ok && !HWRITE;
   end

   // Write address held into the data phase
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= '0;
      end else begin
         wr_pend_reg <= wr_take;
         wr_idx_reg  <= wr_take ? a_idx : wr_idx_reg;
      end
   end

   // ==========================================================
   // Gain trim, only bits 15:7 kept
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         gain_reg <= AGT_GAIN_RST[AGT_GAIN_LSB +: AGT_GAIN_W];
      end else if (wr_pend_reg && wr_idx_reg == AGT_IDX_GAIN) begin
         gain_reg <= HWDATA[AGT_GAIN_LSB +: AGT_GAIN_W];
      end
   end

   // Offset trim, magnitude and sign
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         ofs_mag_reg <= AGT_OFFSET_RST[AGT_OFS_LSB +: AGT_OFS_W];
         ofs_neg_reg <= AGT_OFFSET_RST[AGT_SIGN_BIT];
      end else if (wr_pend_reg && wr_idx_reg == AGT_IDX_OFFSET) begin
         ofs_mag_reg <= HWDATA[AGT_OFS_LSB +: AGT_OFS_W];
         ofs_neg_reg <= HWDATA[AGT_SIGN_BIT];
      end
   end

   // Count of accepted trim writes, wraps
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         wr_cnt_reg <= '0;
      end else if (wr_pend_reg && (wr_idx_reg == AGT_IDX_GAIN || wr_idx_reg == AGT_IDX_OFFSET)) begin
         wr_cnt_reg <= wr_cnt_reg + AGT_CNT_W'(1);
      end
   end

   // ==========================================================
   // Read data, trims never read back
   always_comb begin
      rdata_next = '0;
      if (rd_take && a_idx == AGT_IDX_STATUS) begin
         rdata_next = 32'(wr_cnt_reg);
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Zero wait state, always OKAY
   always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
         HREADYOUT <= 1'b1;
         HRESP     <= AGT_HRESP_OKAY;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= AGT_HRESP_OKAY;
      end
   end

   // ==========================================================
   // Mapper and outputs
   assign trim.gain_code = gain_reg;
   assign trim.ofs_mag   = ofs_mag_reg;
   assign trim.ofs_neg   = ofs_neg_reg;

   agt_trim_map u_map (
      .clk           (SYS_CLK),
      .rst           (SYS_RST),
      .trim          (trim.map),
      .fs_mv_reg     (GAIN_FS_MV),
      .ofs_steps_reg (OFFSET_STEPS)
   );

   assign HRDATA     = rdata_reg;
   assign GAIN_CODE  = gain_reg;
   assign OFFSET_MAG = ofs_mag_reg;
   assign OFFSET_NEG = ofs_neg_reg;
endmodule : agt_trim_regs

// File: tb/agt_trim_regs_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Trim bank checker
module agt_trim_regs_assertions (
   input wire logic                          SYS_CLK,
   input wire logic                          SYS_RST,
   input wire logic                          HSEL,
   input wire logic [31:0]                   HADDR,
   input wire logic [1:0]                    HTRANS,
   input wire logic                          HWRITE,
   input wire logic [2:0]                    HSIZE,
   input wire logic [31:0]                   HWDATA,
   input wire logic                          HREADY,
   input wire logic [31:0]                   HRDATA,
   input wire logic                          HREADYOUT,
   input wire logic                          HRESP,
   input wire logic [agt_pkg::AGT_GAIN_W-1:0] GAIN_CODE,
   input wire logic [agt_pkg::AGT_FS_W-1:0]  GAIN_FS_MV,
   input wire logic [agt_pkg::AGT_OFS_W-1:0] OFFSET_MAG,
   input wire logic                          OFFSET_NEG,
   input wire logic [agt_pkg::AGT_OFS_W:0]   OFFSET_STEPS
);
   import agt_pkg::*;
   localparam logic [31:0] GAIN_A = 32'(AGT_IDX_GAIN) << AGT_ADDR_LSB;
   localparam logic [31:0] OFS_A  = 32'(AGT_IDX_OFFSET) << AGT_ADDR_LSB;
   logic take;
   // Transfer taken this edge
   assign take = HSEL && HREADY && HTRANS == AGT_HTRANS_NSEQ && HSIZE == AGT_HSIZE_WORD;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   // ==========================================
   // Write walks: address phase then data phase
   sequence s_wr_gain; take && HWRITE && HADDR == GAIN_A ##1 1'b1; endsequence
   sequence s_wr_ofs; take && HWRITE && HADDR == OFS_A ##1 1'b1; endsequence
   a_gain_write: assert property (s_wr_gain |=> GAIN_CODE == $past(HWDATA[15:7]))
      else $error("gain code not loaded");
   a_ofs_write: assert property (s_wr_ofs |=> OFFSET_MAG == $past(HWDATA[15:8])
      && OFFSET_NEG == $past(HWDATA[7])) else $error("offset not loaded");
   a_gain_hold: assert property (!$past(take && HWRITE && HADDR == GAIN_A)
      |=> $stable(GAIN_CODE)) else $error("gain code changed without write");
   a_trim_read_zero: assert property (take && !HWRITE && (HADDR == GAIN_A || HADDR == OFS_A)
      |=> HRDATA == '0) else $error("trim register readable");
   a_fs_low: assert property (GAIN_CODE == '0 |=> GAIN_FS_MV == 10'h230)
      else $error("minimum full scale wrong");
   a_fs_mid: assert property (GAIN_CODE == 9'h100 |=> GAIN_FS_MV == 10'h2BC)
      else $error("nominal full scale wrong");
   a_fs_high: assert property (GAIN_CODE == 9'h1FF |=> GAIN_FS_MV == 10'h348)
      else $error("maximum full scale wrong");
   a_steps_pos: assert property (!OFFSET_NEG |=> OFFSET_STEPS == {1'b0, $past(OFFSET_MAG)})
      else $error("positive offset wrong");
   a_steps_neg: assert property (OFFSET_NEG
      |=> OFFSET_STEPS == 9'h000 - {1'b0, $past(OFFSET_MAG)}) else $error("negative offset wrong");
   a_bus_okay: assert property (HREADYOUT && HRESP == AGT_HRESP_OKAY)
      else $error("bus response not OKAY");
endmodule : agt_trim_regs_assertions

bind agt_trim_regs agt_trim_regs_assertions u_chk (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
   .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
   .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .GAIN_CODE(GAIN_CODE), .GAIN_FS_MV(GAIN_FS_MV), .OFFSET_MAG(OFFSET_MAG),
   .OFFSET_NEG(OFFSET_NEG), .OFFSET_STEPS(OFFSET_STEPS));

// File: tb/agt_trim_regs_test.sv
`timescale 1ns/1ps
// ==========================================
// Trim bank bench
module agt_trim_regs_test;
   import agt_pkg::*;
   localparam logic [31:0] GAIN_A = 32'(AGT_IDX_GAIN) << AGT_ADDR_LSB;
   localparam logic [31:0] OFS_A  = 32'(AGT_IDX_OFFSET) << AGT_ADDR_LSB;
   logic SYS_CLK = 1'b0, SYS_RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, HREADYOUT, HRESP, OFFSET_NEG;
   logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, rd;
   logic [8:0]  exp_steps;
   logic [1:0]  HTRANS = 2'h0;
   logic [2:0]  HSIZE  = AGT_HSIZE_WORD;
   logic [8:0]  GAIN_CODE, OFFSET_STEPS;
   logic [9:0]  GAIN_FS_MV;
   logic [7:0]  OFFSET_MAG;
   logic [8:0]  codes [5] = '{9'h000, 9'h0C0, 9'h100, 9'h1C0, 9'h1FF}; // Span ends, midscale and two inner codes
   logic [8:0]  ofs   [4] = '{9'h1FF, 9'h1FE, 9'h003, 9'h000};
   logic [31:0] bad_a [3] = '{32'h0000_000C, 32'h0000_0028, 32'h0000_003C};
   int fail_count = 0, n_tests = 0;
   agt_trim_regs DUT (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .GAIN_CODE(GAIN_CODE),
      .GAIN_FS_MV(GAIN_FS_MV), .OFFSET_MAG(OFFSET_MAG), .OFFSET_NEG(OFFSET_NEG),
      .OFFSET_STEPS(OFFSET_STEPS));
   // Clock
   always #25 SYS_CLK = ~SYS_CLK;
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   // One AHB single transfer, zero or more waits
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      HSEL <= 1'b1; HTRANS <= AGT_HTRANS_NSEQ; HADDR <= a; HWRITE <= w;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      HTRANS <= 2'h0; HWDATA <= d;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask : xfer
   task settle;
      @(posedge SYS_CLK); #1;
   endtask : settle
   task chk_rst;
      chk("gain", 32'h0000_0100, 32'(GAIN_CODE)); // Midscale
      chk("fs", 32'h0000_02BC, 32'(GAIN_FS_MV)); // Nominal
      chk("ofs", 32'h0000_0000, 32'({OFFSET_MAG, OFFSET_NEG, OFFSET_STEPS})); // Zero
   endtask : chk_rst
   task wrap_up;
      if (fail_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   // Watchdog
   initial begin
      #1_000_000;
      fail_count++;
      wrap_up;
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      settle;
      chk_rst; // Power-on values
      foreach (codes[i]) begin
         xfer(1'b1, GAIN_A, {16'h0000, codes[i], 7'h7F});
         settle;
         chk("gain", 32'(codes[i]), 32'(GAIN_CODE)); // Code
         chk("fs", 560 + (codes[i] * 560 + 511) / 1022, 32'(GAIN_FS_MV)); // Scale
      end
      foreach (ofs[i]) begin
         xfer(1'b1, OFS_A, {16'h0000, ofs[i], 7'h7F});
         settle;
         chk("mag", 32'(ofs[i][8:1]), 32'(OFFSET_MAG)); // Magnitude
         chk("neg", 32'(ofs[i][0]), 32'(OFFSET_NEG)); // Sign
         exp_steps = ofs[i][0] ? 9'h000 - {1'b0, ofs[i][8:1]} : {1'b0, ofs[i][8:1]};
         chk("steps", 32'(exp_steps), 32'(OFFSET_STEPS)); // Signed offset
      end
      foreach (bad_a[i]) begin
         xfer(1'b0, bad_a[i], '0);
         chk("rd", '0, rd); // No readback
      end
      xfer(1'b1, 32'h0000_0010, 32'h0000_7F7F); // Unmapped
      settle;
      chk("decode", 32'h0000_01FF, 32'({GAIN_CODE})); // Own address
      chk("decode", '0, 32'({OFFSET_MAG, OFFSET_NEG})); // Own address
      // Byte-sized write must be ignored
      HSIZE <= 3'h0;
      xfer(1'b1, GAIN_A, 32'h0000_607F); // Byte size
      HSIZE <= AGT_HSIZE_WORD;
      settle;
      chk("size", 32'h0000_01FF, 32'(GAIN_CODE)); // Word only
      xfer(1'b0, 32'h0000_0000, '0); // Status
      chk("count", 32'h0000_0009, rd); // Trim writes only
      chk("resp", 32'(AGT_HRESP_OKAY), 32'(HRESP)); // Always OKAY
      SYS_RST <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      SYS_RST <= 1'b0;
      settle;
      chk_rst; // Reset values again
      wrap_up;
   end
endmodule : agt_trim_regs_test
